// file: freq_cmp_pkg.sv
// shared constants, types and register map of the counter channel
package freq_cmp_pkg;

    // register byte offsets
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] compare_offset = 8'h04;
    localparam logic [7:0] hyst_offset = 8'h08;
    localparam logic [7:0] pulse_offset = 8'h0c;
    localparam logic [7:0] integ_offset = 8'h10;
    localparam logic [7:0] count_offset = 8'h14;
    localparam logic [7:0] freq_offset = 8'h18;
    localparam logic [7:0] status_offset = 8'h1c;

    // reset values
    localparam logic [31:0] compare_reset = 32'h0000_0000;
    localparam logic [7:0] hyst_reset = 8'h00;
    localparam logic [7:0] pulse_reset = 8'h00;
    localparam logic [13:0] integ_reset = 14'h0064;

    // hysteresis widths below this value switch hysteresis off
    localparam logic [7:0] hyst_min_active = 8'h02;
    // pulse duration step and integration time limits, in ms
    localparam int pulse_step_ms = 2;
    localparam logic [13:0] integ_min_ms = 14'h000a;
    localparam logic [13:0] integ_max_ms = 14'h2710;
    // clock rate and derived cycles per millisecond
    localparam int clock_hz = 10_000_000;
    localparam int cycles_per_ms = clock_hz / 1000;
    // millihertz scale: edges * 1e6 / integration time in ms
    localparam logic [19:0] mhz_scale = 20'hf4240;
    localparam int edge_w = 27;
    localparam int div_w = 48;
    localparam logic [5:0] div_last = 6'h2f;

    typedef enum logic [1:0] {
        out_none,
        out_at_or_above,
        out_pulse
    } out_mode_t;

    typedef enum logic [1:0] {
        irq_off,
        irq_process,
        irq_diag_process
    } irq_sel_t;

    // control register layout, bit 0 at the right
    typedef struct packed {
        logic end_irq_en;      // [7]
        irq_sel_t irq_sel;     // [6:5]
        logic manual_out;      // [4]
        logic software_gate_bit; // [3]
        out_mode_t out_mode;   // [2:1]
        logic freq_mode;       // [0]
    } ctrl_t;

    // status register layout, bit 0 at the right
    typedef struct packed {
        logic integ_error;     // [5]
        logic irq_pending;     // [4]
        logic gate_open;       // [3]
        logic hyst_active;     // [2]
        logic digital_out;     // [1]
        logic comparator_status_bit; // [0]
    } status_t;

endpackage

// file: freq_cmp_channel.sv
// one counter channel: comparator with hysteresis, frequency meter, wishbone registers
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns

module freq_cmp_channel
    import freq_cmp_pkg::*;
#(
    parameter int cycles_ms = cycles_per_ms
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic pulse_a,
    input wire logic dir_b,
    input wire logic irq_ack,
    output logic digital_out,
    output logic hw_irq,
    output logic diag_irq
);

    ctrl_t ctrl;
    status_t status;
    logic [31:0] compare_value, measured_frequency_value, rd_data;
    logic [7:0] hyst_width, pulse_units;
    logic [13:0] integ_ms;
    logic signed [31:0] count;
    logic integ_error, a_prev, b_prev, a_rise, b_rise, wr, rd_ok;
    // comparator state
    logic upd, last_dir, prev_cond, hyst_active, stored_dir, level;
    logic next_hyst_active, next_stored_dir, next_level;
    logic fire, cond, outside, ge_mode, zero_pulse, pulse_busy;
    logic signed [33:0] count_w, range_hi, range_lo;
    logic [23:0] pulse_left;
    // frequency meter state
    logic running, ms_tick, interval_end, div_busy, div_done, irq_pending;
    logic [23:0] ms_cnt;
    logic [13:0] int_elapsed, int_len, div_den;
    logic [edge_w-1:0] edges;
    logic [5:0] div_step;
    logic [div_w-1:0] div_num;
    logic [14:0] div_rem, rem_shift;
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // wishbone slave
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    always_ff @(posedge clock) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_comb begin
        status = '{integ_error: integ_error, irq_pending: irq_pending,
                   gate_open: ctrl.software_gate_bit, hyst_active: hyst_active,
                   digital_out: digital_out, comparator_status_bit: level || pulse_busy};
        rd_ok = 1'b1;
        case (wb_adr_i[7:0])
            ctrl_offset: rd_data = {24'h000000, ctrl};
            compare_offset: rd_data = compare_value;
            hyst_offset: rd_data = {24'h000000, hyst_width};
            pulse_offset: rd_data = {24'h000000, pulse_units};
            integ_offset: rd_data = {18'h00000, integ_ms};
            count_offset: rd_data = count;
            freq_offset: rd_data = measured_frequency_value;
            status_offset: rd_data = {26'h0000000, status};
            default: begin
                rd_ok = 1'b0;
                rd_data = 32'h0000_0000;
            end
        endcase
        if (wb_adr_i[31:8] != 24'h000000) begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_ok ? rd_data : 32'h0000_0000;
        end
    end
    // writable registers; settings 0..255 and 0..255 x 2 ms fit the fields
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= '0;
            compare_value <= compare_reset;
            hyst_width <= hyst_reset;
            pulse_units <= pulse_reset;
        end else if (wr && wb_adr_i[31:8] == 24'h000000) begin
            case (wb_adr_i[7:0])
                ctrl_offset: begin
                    if (wb_sel_i[0]) begin
                        ctrl <= ctrl_t'(wb_dat_i[7:0]);
                    end
                end
                compare_offset: compare_value <= merge(compare_value, wb_dat_i, wb_sel_i);
                hyst_offset: begin
                    if (wb_sel_i[0]) begin
                        hyst_width <= wb_dat_i[7:0];
                    end
                end
                pulse_offset: begin
                    if (wb_sel_i[0]) begin
                        pulse_units <= wb_dat_i[7:0];
                    end
                end
                default: ;
            endcase
        end
    end
    // integration time accepted only inside 10..10000 ms
    always_ff @(posedge clock) begin
        if (rst) begin
            integ_ms <= integ_reset;
            integ_error <= 1'b0;
        end else if (wr && wb_adr_i == {24'h000000, integ_offset} && wb_sel_i[1:0] == 2'b11) begin
            if (wb_dat_i[31:14] == 18'h00000 && wb_dat_i[13:0] >= integ_min_ms
                    && wb_dat_i[13:0] <= integ_max_ms) begin
                integ_ms <= wb_dat_i[13:0];
                integ_error <= 1'b0;
            end else begin
                integ_error <= 1'b1;
            end
        end
    end
    // input edge detection
    always_ff @(posedge clock) begin
        if (rst) begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end else begin
            a_prev <= pulse_a;
            b_prev <= dir_b;
        end
    end
    assign a_rise = pulse_a && !a_prev;
    assign b_rise = dir_b && !b_prev;
    // ordinary counter
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 32'sh0000_0000;
            upd <= 1'b0;
            last_dir <= 1'b0;
        end else begin
            upd <= 1'b0;
            if (ctrl.software_gate_bit && !ctrl.freq_mode && a_rise) begin
                count <= dir_b ? count - 32'sh0000_0001 : count + 32'sh0000_0001;
                last_dir <= dir_b;
                upd <= 1'b1;
            end
        end
    end
    // comparator with hysteresis
    assign ge_mode = ctrl.out_mode == out_at_or_above;
    assign zero_pulse = pulse_units == 8'h00;
    assign count_w = 34'(count);
    assign range_hi = 34'(signed'(compare_value)) + signed'({26'h0, hyst_width});
    assign range_lo = 34'(signed'(compare_value)) - signed'({26'h0, hyst_width});
    assign outside = count_w > range_hi || count_w < range_lo;
    assign cond = ge_mode ? count >= signed'(compare_value) : count == signed'(compare_value);

    always_comb begin
        next_hyst_active = hyst_active;
        next_stored_dir = stored_dir;
        next_level = level;
        fire = 1'b0;
        if (ctrl.out_mode == out_none || ctrl.freq_mode) begin
            next_hyst_active = 1'b0;
            next_level = 1'b0;
        end else if (upd) begin
            if (hyst_width < hyst_min_active) begin
                next_hyst_active = 1'b0;
                if (ge_mode || zero_pulse) begin
                    next_level = cond;
                end else begin
                    fire = cond && !prev_cond;
                end
            end else if (hyst_active) begin
                if (outside) begin
                    next_hyst_active = 1'b0;
                    if (ge_mode) begin
                        next_level = cond;
                    end else if (zero_pulse) begin
                        next_level = 1'b0;
                    end else if (last_dir != stored_dir) begin
                        fire = 1'b1;
                    end
                    // leaving in stored direction: no pulse
                end else if (ge_mode && !cond) begin
                    next_level = 1'b0;
                end
                // inside range equality repeats nothing
            end else if (cond && !prev_cond) begin
                next_hyst_active = 1'b1;
                next_stored_dir = last_dir;
                if (ge_mode || zero_pulse) begin
                    next_level = 1'b1;
                end else begin
                    fire = 1'b1;
                end
            end else if (ge_mode && !cond) begin
                next_level = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hyst_active <= 1'b0;
            stored_dir <= 1'b0;
            level <= 1'b0;
            prev_cond <= 1'b0;
        end else begin
            hyst_active <= next_hyst_active;
            stored_dir <= next_stored_dir;
            level <= next_level;
            if (upd) begin
                prev_cond <= cond;
            end
        end
    end
    // pulse timer: duration latched at start, no retrigger while running
    always_ff @(posedge clock) begin
        if (rst) begin
            pulse_busy <= 1'b0;
            pulse_left <= 24'h000000;
        end else if (pulse_busy) begin
            pulse_left <= pulse_left - 24'h000001;
            if (pulse_left == 24'h000001) begin
                pulse_busy <= 1'b0;
            end
        end else if (fire && !zero_pulse) begin
            pulse_busy <= 1'b1;
            pulse_left <= 24'(pulse_units * pulse_step_ms * cycles_ms);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            digital_out <= 1'b0;
        end else if (ctrl.out_mode == out_none || ctrl.freq_mode) begin
            digital_out <= ctrl.manual_out && !ctrl.freq_mode;
        end else if (ge_mode || zero_pulse) begin
            digital_out <= next_level;
        end else begin
            digital_out <= pulse_busy && pulse_left != 24'h000001 || fire;
        end
    end
    // frequency meter
    // dedicated per-channel logic, so no sharing limits the rate
    assign running = ctrl.freq_mode && ctrl.software_gate_bit;
    assign ms_tick = ms_cnt == 24'(cycles_ms - 1);
    assign interval_end = running && ms_tick && int_elapsed == int_len - 14'h0001;

    always_ff @(posedge clock) begin
        if (rst || !running) begin
            ms_cnt <= 24'h000000;
            int_elapsed <= 14'h0000;
            int_len <= integ_ms;
            edges <= '0;
        end else begin
            ms_cnt <= ms_tick ? 24'h000000 : ms_cnt + 24'h000001;
            if (interval_end) begin
                int_elapsed <= 14'h0000;
                int_len <= integ_ms;
                edges <= '0;
            end else begin
                if (ms_tick) begin
                    int_elapsed <= int_elapsed + 14'h0001;
                end
                if (b_rise) begin
                    edges <= edges + edge_w'(1);
                end
            end
        end
    end
    // long division: edges * 1e6 / ms, one quotient bit per clock
    assign rem_shift = {div_rem[13:0], div_num[div_w-1]};

    always_ff @(posedge clock) begin
        if (rst) begin
            div_busy <= 1'b0;
            div_step <= 6'h00;
            div_num <= '0;
            div_rem <= 15'h0000;
            div_den <= 14'h0000;
            div_done <= 1'b0;
        end else begin
            div_done <= 1'b0;
            if (interval_end) begin
                div_busy <= 1'b1;
                div_step <= 6'h00;
                div_num <= div_w'((edges + edge_w'(b_rise)) * mhz_scale);
                div_rem <= 15'h0000;
                div_den <= int_len;
            end else if (div_busy) begin
                if (rem_shift >= {1'b0, div_den}) begin
                    div_rem <= rem_shift - {1'b0, div_den};
                    div_num <= {div_num[div_w-2:0], 1'b1};
                end else begin
                    div_rem <= rem_shift;
                    div_num <= {div_num[div_w-2:0], 1'b0};
                end
                div_step <= div_step + 6'h01;
                if (div_step == div_last) begin
                    div_busy <= 1'b0;
                    div_done <= 1'b1;
                end
            end
        end
    end
    // result replaced only when an interval completes; zero edges gives zero
    always_ff @(posedge clock) begin
        if (rst) begin
            measured_frequency_value <= 32'h0000_0000;
        end else if (div_done) begin
            if (div_num[div_w-1:32] != '0) begin
                measured_frequency_value <= 32'hffff_ffff;
            end else begin
                measured_frequency_value <= div_num[31:0];
            end
        end
    end
    // end-of-measurement event and lost-event diagnostic; new event beats ack
    always_ff @(posedge clock) begin
        if (rst) begin
            hw_irq <= 1'b0;
            diag_irq <= 1'b0;
            irq_pending <= 1'b0;
        end else begin
            hw_irq <= 1'b0;
            diag_irq <= 1'b0;
            if (div_done && ctrl.end_irq_en && ctrl.irq_sel != irq_off) begin
                hw_irq <= 1'b1;
                irq_pending <= 1'b1;
                if (irq_pending && !irq_ack && ctrl.irq_sel == irq_diag_process) begin
                    diag_irq <= 1'b1;
                end
            end else if (irq_ack) begin
                irq_pending <= 1'b0;
            end
        end
    end

endmodule

// file: freq_cmp_channel_assertions.sv
// port checker for the counter channel, bound to the channel module
`timescale 1ns/1ns
module freq_cmp_channel_checker
    import freq_cmp_pkg::*;
#(
    parameter int cycles_ms = cycles_per_ms
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pulse_a,
    input wire logic dir_b,
    input wire logic irq_ack,
    input wire logic digital_out,
    input wire logic hw_irq,
    input wire logic diag_irq
);
    logic [7:0] ctrl;
    logic [7:0] pulse;
    logic [13:0] integ;
    logic ir_ok;
    int ir_cnt;
    int hi_cnt;
    logic wr;
    logic adr_hi;
    assign adr_hi = wb_adr_i[31:8] == 24'h000000;
    assign wr = wb_ack_o && wb_we_i && adr_hi;
    // shadow of the settings written over the bus
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= 8'h00;
            pulse <= pulse_reset;
            integ <= integ_reset;
        end else if (wr) begin
            if (wb_adr_i[7:0] == ctrl_offset && wb_sel_i[0])
                ctrl <= wb_dat_i[7:0];
            if (wb_adr_i[7:0] == pulse_offset && wb_sel_i[0])
                pulse <= wb_dat_i[7:0];
            if (wb_adr_i[7:0] == integ_offset && wb_sel_i[1:0] == 2'h3
                && wb_dat_i >= 32'(integ_min_ms) && wb_dat_i <= 32'(integ_max_ms))
                integ <= wb_dat_i[13:0];
        end
    end
    // cycles since the last end-of-measurement pulse
    always_ff @(posedge clock) begin
        if (rst || wr) begin
            ir_ok <= 1'b0;
            ir_cnt <= 0;
        end else if (hw_irq) begin
            ir_ok <= 1'b1;
            ir_cnt <= 0;
        end else begin
            ir_cnt <= ir_cnt + 1;
        end
    end
    // length of the current high phase of the output
    always_ff @(posedge clock) begin
        if (rst || !digital_out)
            hi_cnt <= 0;
        else
            hi_cnt <= hi_cnt + 1;
    end
    a_ack_answer: assert property (@(posedge clock) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_ack_single: assert property (@(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (@(posedge clock) disable iff (rst)
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_quiet: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !digital_out && !hw_irq && !diag_irq && !wb_ack_o && wb_dat_o == 32'h0)
        else $error("outputs not cleared by reset");
    a_irq_enabled: assert property (
        @(posedge clock) disable iff (rst) hw_irq |-> ctrl[0] && ctrl[7])
        else $error("measurement pulse while not enabled");
    a_irq_period: assert property (
        @(posedge clock) disable iff (rst)
        hw_irq && ir_ok |-> ir_cnt == int'(integ) * cycles_ms - 1)
        else $error("measurement interval length wrong");
    a_irq_single: assert property (
        @(posedge clock) disable iff (rst) hw_irq |=> !hw_irq)
        else $error("measurement pulse longer than one cycle");
    a_diag_mode: assert property (
        @(posedge clock) disable iff (rst) diag_irq |-> ctrl[6:5] == 2'h2 && !$past(diag_irq))
        else $error("diagnostic pulse outside diagnostic mode");
    a_pulse_width: assert property (
        @(posedge clock) disable iff (rst)
        $fell(digital_out) && ctrl[2:1] == 2'h2 && pulse != 8'h00
        |-> hi_cnt == int'(pulse) * pulse_step_ms * cycles_ms)
        else $error("output pulse width wrong");
endmodule
bind freq_cmp_channel freq_cmp_channel_checker #(.cycles_ms(cycles_ms)) chk (
    .clock(clock), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pulse_a(pulse_a), .dir_b(dir_b),
    .irq_ack(irq_ack), .digital_out(digital_out), .hw_irq(hw_irq), .diag_irq(diag_irq)
);

// file: pulse_source.sv
// external pulse source feeding the count and measured inputs
`timescale 1ns/1ns
module pulse_source (
    input wire logic clock,
    output logic pulse_a,
    output logic dir_b
);
    logic dir_cmd = 1'b0;
    logic wave_on = 1'b0;
    logic wave = 1'b0;
    int phase = 0;
    initial pulse_a = 1'b0;
    // measured square wave shares the direction input
    assign dir_b = wave_on ? wave : dir_cmd;
    // period of ten clock cycles while running
    always @(posedge clock) begin
        if (wave_on && phase == 4) begin
            wave <= !wave;
            phase <= 0;
        end else if (wave_on) begin
            phase <= phase + 1;
        end
    end
    task automatic step(input int n, input logic down);
        dir_cmd <= down;
        repeat (n) begin
            @(posedge clock);
            pulse_a <= 1'b1;
            repeat (2) @(posedge clock);
            pulse_a <= 1'b0;
            @(posedge clock);
        end
        repeat (3) @(posedge clock);
    endtask
    task automatic wave_ctl(input logic on);
        wave_on <= on;
    endtask
endmodule

// file: freq_cmp_channel_test.sv
// self-checking bench for the counter channel
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
        end \
    end
module freq_cmp_channel_test
    import freq_cmp_pkg::*;
;
    localparam int cms = 10;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd_dat;
    logic [31:0] rdat;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack;
    logic irq_ack = 1'b0;
    logic pulse_a;
    logic dir_b;
    logic digital_out;
    logic hw_irq;
    logic diag_irq;
    int n_mismatch = 0;
    int compares = 0;
    int n_irq = 0;
    int n_diag = 0;
    freq_cmp_channel #(.cycles_ms(cms)) dut (
        .clock(clock), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rd_dat),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .pulse_a(pulse_a), .dir_b(dir_b), .irq_ack(irq_ack), .digital_out(digital_out),
        .hw_irq(hw_irq), .diag_irq(diag_irq)
    );
    pulse_source src (.clock(clock), .pulse_a(pulse_a), .dir_b(dir_b));
    initial forever #50 clock = ~clock;
    always @(posedge clock) begin
        if (hw_irq === 1'b1) n_irq++;
        if (diag_irq === 1'b1) n_diag++;
    end
    task automatic tally_and_finish;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        src.wave_ctl(1'b0);
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h000000, a};
        wdat <= d;
        sel <= 4'hf;
        @(posedge clock);
        while (ack !== 1'b1 && t < 20) begin
            @(posedge clock);
            t++;
        end
        `CHK(ack, 1'b1)
        rdat = rd_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic out_is(input logic e);
        @(negedge clock);
        `CHK(digital_out, e)
        @(posedge clock);
    endtask
    task automatic wait_irq;
        int t;
        t = 0;
        @(posedge clock);
        while (hw_irq !== 1'b1 && t < 400) begin
            @(posedge clock);
            t++;
        end
        `CHK(hw_irq, 1'b1)
    endtask
    task automatic setup(input logic [31:0] c, input logic [31:0] h, input logic [31:0] p);
        do_reset;
        xfer(1'b1, compare_offset, c);
        xfer(1'b1, hyst_offset, h);
        xfer(1'b1, pulse_offset, p);
    endtask
    task automatic t_regs;
        do_reset;
        xfer(1'b0, integ_offset, 32'h0);
        `CHK(rdat, 32'h00000064)
        xfer(1'b0, hyst_offset, 32'h0);
        `CHK(rdat, 32'h00000000)
        xfer(1'b1, integ_offset, 32'h00000009);
        xfer(1'b0, status_offset, 32'h0);
        `CHK(rdat[5], 1'b1)
        xfer(1'b1, integ_offset, 32'h00002710);
        xfer(1'b0, integ_offset, 32'h0);
        `CHK(rdat, 32'h00002710)
        xfer(1'b0, 8'h20, 32'h0);
        `CHK(rdat, 32'h00000000)
        xfer(1'b1, ctrl_offset, 32'h00000010);
        out_is(1'b1);
    endtask
    task automatic t_above;
        setup(32'h5, 32'h2, 32'h0);
        xfer(1'b1, ctrl_offset, 32'h0a);
        src.step(5, 1'b0);
        out_is(1'b1);
        src.step(1, 1'b1);
        out_is(1'b0);
        src.step(1, 1'b0);
        out_is(1'b0);
        src.step(3, 1'b0);
        out_is(1'b1);
    endtask
    task automatic t_nohyst;
        setup(32'h5, 32'h1, 32'h0);
        xfer(1'b1, ctrl_offset, 32'h0a);
        src.step(5, 1'b0);
        out_is(1'b1);
        src.step(1, 1'b1);
        out_is(1'b0);
        src.step(1, 1'b0);
        out_is(1'b1);
    endtask
    task automatic t_pulse0;
        setup(32'h3, 32'h2, 32'h0);
        xfer(1'b1, ctrl_offset, 32'h0c);
        src.step(3, 1'b0);
        out_is(1'b1);
        src.step(1, 1'b0);
        src.step(1, 1'b1);
        out_is(1'b1);
        src.step(3, 1'b0);
        out_is(1'b0);
    endtask
    task automatic t_pulsen;
        setup(32'h3, 32'h2, 32'h1);
        xfer(1'b1, ctrl_offset, 32'h0c);
        src.step(3, 1'b0);
        out_is(1'b1);
        repeat (30) @(posedge clock);
        out_is(1'b0);
        src.step(1, 1'b1);
        src.step(1, 1'b0);
        out_is(1'b0);
        src.step(3, 1'b1);
        out_is(1'b1);
        repeat (30) @(posedge clock);
        src.step(3, 1'b0);
        out_is(1'b1);
        repeat (30) @(posedge clock);
        src.step(3, 1'b0);
        out_is(1'b0);
    endtask
    task automatic t_freq;
        int snap;
        do_reset;
        irq_ack <= 1'b1;
        xfer(1'b1, integ_offset, 32'h0000000a);
        xfer(1'b1, ctrl_offset, 32'ha9);
        src.wave_ctl(1'b1);
        src.step(3, 1'b0);
        xfer(1'b0, count_offset, 32'h0);
        `CHK(rdat, 32'h00000000)
        repeat (3) wait_irq;
        src.wave_ctl(1'b0);
        xfer(1'b0, freq_offset, 32'h0);
        `CHK(rdat, 32'h000f4240)
        repeat (2) wait_irq;
        xfer(1'b0, freq_offset, 32'h0);
        `CHK(rdat, 32'h00000000)
        `CHK(n_diag, 0)
        irq_ack <= 1'b0;
        xfer(1'b1, ctrl_offset, 32'hc9);
        repeat (2) wait_irq;
        `CHK(diag_irq, 1'b1)
        xfer(1'b1, ctrl_offset, 32'ha1);
        `CHK(n_diag > 0, 1'b1)
        repeat (100) @(posedge clock);
        snap = n_irq;
        repeat (300) @(posedge clock);
        `CHK(n_irq, snap)
        xfer(1'b1, ctrl_offset, 32'ha9);
        wait_irq;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish;
    end
    initial begin
        t_regs;
        t_above;
        t_nohyst;
        t_pulse0;
        t_pulsen;
        t_freq;
        tally_and_finish;
    end
endmodule
